// *** aofs_top.v ***
/*
 * Fault and status reporting for a six-channel analog output module.
 * Builds channel condition words, the per-channel fault word and the
 * module fault summary word, and presents them with every data transfer.
 * Assumes all inputs are synchronous to clk_in except the comm-fail and
 * calibration status levels from the link, which are synchronised here.
 */
// What this block does
// - NaN request sets flag, output keeps value
// - Calibration error sets flag and fault bit
// - Any calibration error sets summary bit 11
// - Hold flag clears within 0.1% of full scale of echo
// - Slew alarm, latched or until target reached
// - Floor alarm, latched or until request rises
// - Ceiling alarm, latched or until request falls
// - Either limit alarm sets channel fault bit
// - Float mode bits 6 and 7 read zero
// - Fault bit sets summary bits 15, 13
// - Calibrating sets bit 12 and fault bits
// - One fault bit per channel, bits 5..0
// - Calibrating gives 003F, comm failure FFFF
// - Integer mode: one word, hold only
// - Integer hold bits: channel 0 at 14
// - Integer odd bits 15..5 read zero
// - Integer omits cal errors, summary keeps them
// - Status words sent with each transfer
`timescale 1ns/1ps
`default_nettype none
`include "aofs_consts.vh"

module aofs_top (
    input wire clk_in,
    input wire rst_in,
    input wire float_mode_in,
    input wire comm_fail_in,
    input wire [5:0] calibrating_in,
    input wire [5:0] cal_error_in,
    input wire [5:0] hold_enter_in,
    input wire [5:0] latch_en_in,
    input wire [5:0] unlatch_in,
    input wire [5:0] at_target_in,
    input wire [191:0] request_raw_in,
    input wire [191:0] request_in,
    input wire [191:0] echo_in,
    input wire [31:0] full_scale_in,
    input wire [191:0] floor_in,
    input wire [191:0] ceiling_in,
    input wire [191:0] max_step_in,
    input wire transfer_in,
    output reg [5:0] out_update_q_out,
    output reg [5:0] hold_q_out,
    output reg [15:0] module_fault_summary_word_q_out,
    output reg [15:0] per_channel_fault_word_q_out,
    output reg [95:0] channel_condition_word_q_out,
    output reg transfer_valid_q_out
);

    // ------------------------------------------------------------
    // Synchronisers for link-side status levels
    // ------------------------------------------------------------
    reg comm_meta_q;
    reg comm_q;
    reg [5:0] calib_meta_q;
    reg [5:0] calib_q;
    reg [5:0] calerr_meta_q;
    reg [5:0] calerr_q;

    always @(posedge clk_in) begin
        if (rst_in) begin
            comm_meta_q <= 1'b0;
            comm_q <= 1'b0;
            calib_meta_q <= 6'h00;
            calib_q <= 6'h00;
            calerr_meta_q <= 6'h00;
            calerr_q <= 6'h00;
        end else begin
            comm_meta_q <= comm_fail_in;
            comm_q <= comm_meta_q;
            calib_meta_q <= calibrating_in;
            calib_q <= calib_meta_q;
            calerr_meta_q <= cal_error_in;
            calerr_q <= calerr_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Per-channel condition flags
    // ------------------------------------------------------------
    wire [5:0] nan_w;
    wire [5:0] hold_rel_w;
    wire [5:0] slew_w;
    wire [5:0] low_w;
    wire [5:0] high_w;
    reg [5:0] hold_d;

    genvar gi;
    generate
        for (gi = 0; gi < `AOFS_NCH; gi = gi + 1) begin : g_chan
            aofs_chan u_chan (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .float_mode_in(float_mode_in),
                .request_raw_in(request_raw_in[gi*32 +: 32]),
                .request_in(request_in[gi*32 +: 32]),
                .echo_in(echo_in[gi*32 +: 32]),
                .full_scale_in(full_scale_in),
                .floor_in(floor_in[gi*32 +: 32]),
                .ceiling_in(ceiling_in[gi*32 +: 32]),
                .max_step_in(max_step_in[gi*32 +: 32]),
                .latch_en_in(latch_en_in[gi]),
                .unlatch_in(unlatch_in[gi]),
                .update_in(transfer_in),
                .at_target_in(at_target_in[gi]),
                .nan_q_out(nan_w[gi]),
                .hold_q_out(hold_rel_w[gi]),
                .slew_q_out(slew_w[gi]),
                .low_q_out(low_w[gi]),
                .high_q_out(high_w[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Hold flag and output update enables
    // ------------------------------------------------------------
    // Release window computed here, entry from outside; entry wins
    function in_hold_window;
        input signed [31:0] req;
        input signed [31:0] ech;
        input [31:0] fs;
        reg signed [32:0] df;
        reg [32:0] ad;
        begin
            df = {req[31], req} - {ech[31], ech};
            ad = df[32] ? (33'h000000000 - df) : df;
            in_hold_window = ({31'h00000000, ad} * 64'd`AOFS_HOLD_WIN_DEN) <=
                ({32'h00000000, fs} * 64'd`AOFS_HOLD_WIN_NUM);
        end
    endfunction

    integer hi;
    always @* begin
        hold_d = hold_q_out;
        for (hi = 0; hi < `AOFS_NCH; hi = hi + 1) begin
            if (hold_enter_in[hi])
                hold_d[hi] = 1'b1;
            else if (transfer_in && hold_q_out[hi] &&
                in_hold_window(request_in[hi*32 +: 32], echo_in[hi*32 +: 32], full_scale_in))
                hold_d[hi] = 1'b0;
        end
    end

    integer ui;
    always @(posedge clk_in) begin
        if (rst_in) begin
            hold_q_out <= 6'h00;
            out_update_q_out <= 6'h00;
        end else begin
            hold_q_out <= hold_d;
            for (ui = 0; ui < `AOFS_NCH; ui = ui + 1)
                // NaN or holding keeps the previous output value
                out_update_q_out[ui] <= transfer_in && !hold_d[ui] && !(float_mode_in &&
                    (request_raw_in[ui*32+23 +: 8] == `AOFS_EXP_ONES) &&
                    (request_raw_in[ui*32 +: 23] != 23'h000000));
        end
    end

    // ------------------------------------------------------------
    // Word assembly
    // ------------------------------------------------------------
    reg [15:0] chan_fault_d;
    reg [15:0] summary_d;
    reg [95:0] cond_d;
    reg [15:0] int_word;
    integer wi;

    always @* begin
        chan_fault_d = `AOFS_ZERO_WORD;
        cond_d = 96'h0;
        int_word = `AOFS_ZERO_WORD;
        summary_d = `AOFS_ZERO_WORD;
        for (wi = 0; wi < `AOFS_NCH; wi = wi + 1) begin
            chan_fault_d[wi] = low_w[wi] | high_w[wi] | calerr_q[wi];
            int_word[`AOFS_INT_HOLD_TOP - 2*wi] = hold_q_out[wi];
        end
        if (comm_q)
            chan_fault_d = `AOFS_CF_COMM_FAIL;
        else if (|calib_q)
            chan_fault_d = `AOFS_CF_CALIBRATING;
        if (float_mode_in == `AOFS_MODE_FLOAT) begin
            for (wi = 0; wi < `AOFS_NCH; wi = wi + 1) begin
                // Bits 15..6 stay zero
                cond_d[wi*16 + `AOFS_FP_NAN_BIT] = nan_w[wi];
                cond_d[wi*16 + `AOFS_FP_CAL_BIT] = calerr_q[wi];
                cond_d[wi*16 + `AOFS_FP_HOLD_BIT] = hold_q_out[wi];
                cond_d[wi*16 + `AOFS_FP_SLEW_BIT] = slew_w[wi];
                cond_d[wi*16 + `AOFS_FP_LOW_BIT] = low_w[wi];
                cond_d[wi*16 + `AOFS_FP_HIGH_BIT] = high_w[wi];
            end
        end else begin
            cond_d[15:0] = int_word;
        end
        summary_d[`AOFS_MF_ANALOG_BIT] = |chan_fault_d;
        summary_d[`AOFS_MF_OUTPUT_BIT] = |chan_fault_d;
        summary_d[`AOFS_MF_CALIBRATING_BIT] = |calib_q;
        summary_d[`AOFS_MF_CALERR_BIT] = |calerr_q;
    end

    // ------------------------------------------------------------
    // Reported words, refreshed every cycle, flagged per transfer
    // ------------------------------------------------------------
    always @(posedge clk_in) begin
        if (rst_in) begin
            module_fault_summary_word_q_out <= `AOFS_ZERO_WORD;
            per_channel_fault_word_q_out <= `AOFS_ZERO_WORD;
            channel_condition_word_q_out <= 96'h0;
            transfer_valid_q_out <= 1'b0;
        end else begin
            module_fault_summary_word_q_out <= summary_d;
            per_channel_fault_word_q_out <= chan_fault_d;
            channel_condition_word_q_out <= cond_d;
            transfer_valid_q_out <= transfer_in;
        end
    end

    // hold_rel_w mirrors release in the channel but the top owns the hold flag
endmodule // aofs_top

`default_nettype wire

// *** aofs_consts.vh ***
/*
 * Constants for the analog output fault and status reporting block:
 * word widths, bit positions and fixed word values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef AOFS_CONSTS_VH
`define AOFS_CONSTS_VH

`define AOFS_NCH 6
`define AOFS_WORD_W 16
`define AOFS_VAL_W 32
// Channel condition word, floating point layout
`define AOFS_FP_NAN_BIT 5
`define AOFS_FP_CAL_BIT 4
`define AOFS_FP_HOLD_BIT 3
`define AOFS_FP_SLEW_BIT 2
`define AOFS_FP_LOW_BIT 1
`define AOFS_FP_HIGH_BIT 0
// Integer layout: channel 0 at bit 14, two bits lower per channel
`define AOFS_INT_HOLD_TOP 14
// Module fault summary word
`define AOFS_MF_ANALOG_BIT 15
`define AOFS_MF_OUTPUT_BIT 13
`define AOFS_MF_CALIBRATING_BIT 12
`define AOFS_MF_CALERR_BIT 11
// Per-channel fault word fixed values
`define AOFS_CF_CALIBRATING 16'h003f
`define AOFS_CF_COMM_FAIL 16'hffff
`define AOFS_ZERO_WORD 16'h0000
// Hold release window: 0.1 % of full scale, as numerator / denominator
`define AOFS_HOLD_WIN_NUM 1
`define AOFS_HOLD_WIN_DEN 1000
// IEEE single precision NaN detection
`define AOFS_EXP_ONES 8'hff
`define AOFS_MODE_FLOAT 1'b1

`endif

// *** aofs_chan.v ***
/*
 * One output channel's condition flags: NaN, hold, slew alarm,
 * floor and ceiling alarms with optional latching.
 * Assumes values and limits arrive already in one signed integer
 * scale on clk_in; calibration error is formed outside.
 */
`timescale 1ns/1ps
`default_nettype none
`include "aofs_consts.vh"

module aofs_chan (
    input wire clk_in,
    input wire rst_in,
    input wire float_mode_in,
    input wire [31:0] request_raw_in,
    input wire signed [31:0] request_in,
    input wire signed [31:0] echo_in,
    input wire signed [31:0] full_scale_in,
    input wire signed [31:0] floor_in,
    input wire signed [31:0] ceiling_in,
    input wire signed [31:0] max_step_in,
    input wire latch_en_in,
    input wire unlatch_in,
    input wire update_in,
    input wire at_target_in,
    output reg nan_q_out,
    output reg hold_q_out,
    output reg slew_q_out,
    output reg low_q_out,
    output reg high_q_out
);

    wire is_nan;
    wire signed [32:0] diff;
    wire [32:0] diff_abs;
    wire [63:0] win_lhs;
    wire [63:0] win_rhs;
    wire in_window;
    wire signed [32:0] step;
    wire [32:0] step_abs;
    wire slew_cond;
    wire low_cond;
    wire high_cond;

    // A NaN request must not reach the hold or limit logic
    assign is_nan = float_mode_in &&
        (request_raw_in[30:23] == `AOFS_EXP_ONES) && (request_raw_in[22:0] != 23'h000000);
    assign diff = {request_in[31], request_in} - {echo_in[31], echo_in};
    assign diff_abs = diff[32] ? (33'h000000000 - diff) : diff;
    // Multiply out instead of dividing, so no divider is needed
    assign win_lhs = {31'h00000000, diff_abs} * 64'd`AOFS_HOLD_WIN_DEN;
    assign win_rhs = {32'h00000000, full_scale_in[31:0]} * 64'd`AOFS_HOLD_WIN_NUM;
    assign in_window = (win_lhs <= win_rhs);
    assign step = {request_in[31], request_in} - {echo_in[31], echo_in};
    assign step_abs = step[32] ? (33'h000000000 - step) : step;
    assign slew_cond = (step_abs > {1'b0, max_step_in});
    assign low_cond = (request_in < floor_in);
    assign high_cond = (request_in > ceiling_in);

    always @(posedge clk_in) begin
        if (rst_in) begin
            nan_q_out <= 1'b0;
            hold_q_out <= 1'b0;
            slew_q_out <= 1'b0;
            low_q_out <= 1'b0;
            high_q_out <= 1'b0;
        end else if (update_in) begin
            nan_q_out <= is_nan;
            if (!is_nan) begin
                // Hold release needs the request close to the echo
                if (hold_q_out && in_window)
                    hold_q_out <= 1'b0;
                // Set wins over unlatch: only clear when condition gone
                if (slew_cond)
                    slew_q_out <= 1'b1;
                else if (latch_en_in ? unlatch_in : at_target_in)
                    slew_q_out <= 1'b0;
                if (low_cond)
                    low_q_out <= 1'b1;
                else if (!latch_en_in || unlatch_in)
                    low_q_out <= 1'b0;
                if (high_cond)
                    high_q_out <= 1'b1;
                else if (!latch_en_in || unlatch_in)
                    high_q_out <= 1'b0;
            end
        end else begin
            if (latch_en_in && unlatch_in) begin
                if (!slew_cond && !slew_q_out)
                    slew_q_out <= 1'b0;
                else if (!slew_cond)
                    slew_q_out <= 1'b0;
                if (!low_cond)
                    low_q_out <= 1'b0;
                if (!high_cond)
                    high_q_out <= 1'b0;
            end
            if (!latch_en_in && at_target_in)
                slew_q_out <= 1'b0;
        end
    end

    // Hold is entered from outside via the hold request path in the top;
    // here it only tracks the release window.
endmodule // aofs_chan

`default_nettype wire

// *** aofs_top_props.sv ***
/* Checker for aofs_top: timing and layout of the status words.
   Assumes one clock clk_in and rst_in synchronous, active high. */
`timescale 1ns/1ps
`default_nettype none
module aofs_top_props (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic float_mode_in,
    input wire logic comm_fail_in,
    input wire logic [5:0] calibrating_in,
    input wire logic [5:0] cal_error_in,
    input wire logic [191:0] request_raw_in,
    input wire logic transfer_in,
    input wire logic [5:0] out_update_q_out,
    input wire logic [5:0] hold_q_out,
    input wire logic [15:0] module_fault_summary_word_q_out,
    input wire logic [15:0] per_channel_fault_word_q_out,
    input wire logic [95:0] channel_condition_word_q_out,
    input wire logic transfer_valid_q_out
);
    wire logic [15:0] mf = module_fault_summary_word_q_out;
    wire logic [15:0] pc = per_channel_fault_word_q_out;
    wire logic [95:0] cw = channel_condition_word_q_out;
    default clocking dc @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // Async levels pass a two-stage sync, so five steady cycles are ample
    property p_comm; comm_fail_in [*5] |-> pc == 16'hffff; endproperty
    a_comm: assert property (p_comm) else $error("comm fail word");
    property p_calib;
        (!comm_fail_in && calibrating_in != 6'h00) [*5] |-> pc == 16'h003f && mf[12];
    endproperty
    a_calib: assert property (p_calib) else $error("calibrating word");
    property p_calerr; (cal_error_in != 6'h00) [*5] |-> mf[11]; endproperty
    a_calerr: assert property (p_calerr) else $error("cal error summary");
    property p_cerr_bit;
        (cal_error_in != 6'h00 && $stable(cal_error_in) && !comm_fail_in
            && calibrating_in == 6'h00) [*5] |-> (pc[5:0] & cal_error_in) == cal_error_in;
    endproperty
    a_cerr_bit: assert property (p_cerr_bit) else $error("cal error bit");
    property p_grp; (pc != 16'h0000) [*2] |-> mf[15] && mf[13]; endproperty
    a_grp: assert property (p_grp) else $error("group bits clear");
    property p_grp_off; (pc == 16'h0000) [*2] |-> !mf[15] && !mf[13]; endproperty
    a_grp_off: assert property (p_grp_off) else $error("group bits set");
    property p_b14; !mf[14]; endproperty
    a_b14: assert property (p_b14) else $error("summary bit 14 set");
    property p_fp; float_mode_in [*3] |-> (cw & {6{16'h00c0}}) == 96'h0; endproperty
    a_fp: assert property (p_fp) else $error("float unused bits");
    property p_int;
        !float_mode_in [*3] |-> cw[95:16] == 80'h0 && (cw[15:0] & 16'haaaf) == 16'h0;
    endproperty
    a_int: assert property (p_int) else $error("integer unused bits");
    property p_ihold;
        !float_mode_in [*3] |-> cw[4] == $past(hold_q_out[5]) && cw[14] == $past(hold_q_out[0]);
    endproperty
    a_ihold: assert property (p_ihold) else $error("integer hold bit");
    property p_fhold;
        float_mode_in [*3] |->
            {cw[83], cw[67], cw[51], cw[35], cw[19], cw[3]} == $past(hold_q_out);
    endproperty
    a_fhold: assert property (p_fhold) else $error("float hold bit");
    property p_valid; transfer_in |=> transfer_valid_q_out; endproperty
    a_valid: assert property (p_valid) else $error("no valid");
    property p_novalid; !transfer_in |=> !transfer_valid_q_out; endproperty
    a_novalid: assert property (p_novalid) else $error("stray valid");
    property p_nan;
        float_mode_in && transfer_in && request_raw_in[30:23] == 8'hff
            && request_raw_in[22:0] != 23'h0 |=> !out_update_q_out[0];
    endproperty
    a_nan: assert property (p_nan) else $error("nan updated");
endmodule // aofs_top_props
bind aofs_top aofs_top_props aofs_top_props_i (.clk_in, .rst_in, .float_mode_in,
    .comm_fail_in, .calibrating_in, .cal_error_in, .request_raw_in, .transfer_in,
    .out_update_q_out, .hold_q_out, .module_fault_summary_word_q_out,
    .per_channel_fault_word_q_out, .channel_condition_word_q_out, .transfer_valid_q_out);
`default_nettype wire

// *** aofs_ctrl_model.sv ***
/* Controller side: keeps the words that came with the last transfer.
   Assumes the words are meaningful only while valid_in is high. */
`timescale 1ns/1ps
`default_nettype none
module aofs_ctrl_model (
    input wire logic clk_in,
    input wire logic valid_in,
    input wire logic [15:0] mf_in,
    input wire logic [15:0] pc_in,
    output var logic [15:0] mf_out,
    output var logic [15:0] pc_out
);
    // Sampling free-running words would hide a missing transfer pulse
    always @(posedge clk_in) begin
        if (valid_in) begin
            mf_out <= mf_in;
            pc_out <= pc_in;
        end
    end
endmodule // aofs_ctrl_model
`default_nettype wire

// *** aofs_top_tb.sv ***
/* Self-checking bench for aofs_top with a controller model.
   Assumes a 40 ns clock and transfers spaced by at least three cycles. */
`timescale 1ns/1ps
`default_nettype none
module aofs_top_tb;
    typedef struct packed {
        logic [13:0] in; logic [15:0] mf; logic [15:0] pc;
    } aofs_row_t;
    logic clk_in, rst_in, float_mode_in, comm_fail_in, transfer_in, tv_s;
    logic [5:0] calibrating_in, cal_error_in, hold_enter_in, latch_en_in, unlatch_in;
    logic [5:0] at_target_in, upd_s, upd, hq;
    logic [191:0] request_raw_in, request_in, echo_in, floor_in, ceiling_in, max_step_in;
    logic [31:0] full_scale_in;
    logic [15:0] mf, pc, snap_mf, snap_pc;
    logic [95:0] cw, ecw;
    logic tv;
    int failures = 0;
    int total_checks = 0;
    // Inputs: float, comm fail, calibrating, cal error
    aofs_row_t rows [8] = '{
        {1'b1, 1'b0, 6'h00, 6'h00, 16'h0000, 16'h0000},
        {1'b1, 1'b1, 6'h00, 6'h00, 16'ha000, 16'hffff},
        {1'b1, 1'b0, 6'h01, 6'h00, 16'hb000, 16'h003f},
        {1'b1, 1'b0, 6'h00, 6'h04, 16'ha800, 16'h0004},
        {1'b1, 1'b1, 6'h02, 6'h00, 16'hb000, 16'hffff},
        {1'b0, 1'b0, 6'h00, 6'h20, 16'ha800, 16'h0020},
        {1'b0, 1'b0, 6'h10, 6'h00, 16'hb000, 16'h003f},
        {1'b1, 1'b0, 6'h00, 6'h00, 16'h0000, 16'h0000}};
    aofs_top aofs_top_i (.clk_in, .rst_in, .float_mode_in, .comm_fail_in, .calibrating_in,
        .cal_error_in, .hold_enter_in, .latch_en_in, .unlatch_in, .at_target_in,
        .request_raw_in, .request_in, .echo_in, .full_scale_in, .floor_in, .ceiling_in,
        .max_step_in, .transfer_in, .out_update_q_out(upd), .hold_q_out(hq),
        .module_fault_summary_word_q_out(mf), .per_channel_fault_word_q_out(pc),
        .channel_condition_word_q_out(cw), .transfer_valid_q_out(tv));
    aofs_ctrl_model aofs_ctrl_model_i (.clk_in, .valid_in(tv), .mf_in(mf), .pc_in(pc),
        .mf_out(snap_mf), .pc_out(snap_pc));
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    task chk(input string nm, input logic [127:0] e, input logic [127:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task results;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Pulses are registered on the taken edge itself, words one cycle later
    task xfer;
        transfer_in = 1'b1;
        @(posedge clk_in);
        #1;
        upd_s = upd;
        tv_s = tv;
        transfer_in = 1'b0;
        unlatch_in = 6'h00;
        repeat (2) @(posedge clk_in);
        #1;
    endtask
    initial begin
        #2000000;
        failures++;
        results;
    end
    initial begin
        {rst_in, float_mode_in, comm_fail_in, transfer_in} = 4'b1100;
        {calibrating_in, cal_error_in, hold_enter_in, latch_en_in} = 24'h0;
        {unlatch_in, at_target_in, request_raw_in, request_in, echo_in} = '0;
        floor_in = {6{32'hfffffc18}};
        ceiling_in = {6{32'h000003e8}};
        max_step_in = {6{32'h01000000}};
        full_scale_in = 32'h00002710;
        repeat (12) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        chk("reset", 128'h0, {mf, pc, cw});
        foreach (rows[i]) begin
            {float_mode_in, comm_fail_in, calibrating_in, cal_error_in} = rows[i].in;
            repeat (4) @(posedge clk_in);
            #1;
            xfer;
            ecw = '0;
            for (int n = 0; n < 6; n++) ecw[16*n+4] = rows[i].in[13] & rows[i].in[n];
            chk("mf", rows[i].mf, mf);
            chk("pc", rows[i].pc, pc);
            chk("cw", ecw, cw);
            chk("snap", {rows[i].mf, rows[i].pc}, {snap_mf, snap_pc});
            chk("tv", 1'b1, tv_s);
        end
        request_in[63:32] = 32'hfffff830;
        xfer;
        chk("floor", 2'b11, {cw[17], pc[1]});
        request_in[63:32] = 32'h0;
        request_in[159:128] = 32'h000007d0;
        latch_en_in = 6'h10;
        xfer;
        chk("floor off", 3'b001, {cw[17], pc[1], cw[64]});
        unlatch_in = 6'h10;
        xfer;
        chk("unlatch busy", 1'b1, cw[64]);
        request_in[159:128] = 32'h0;
        xfer;
        chk("latched", 2'b11, {cw[64], pc[4]});
        unlatch_in = 6'h10;
        xfer;
        chk("unlatched", 1'b0, cw[64]);
        max_step_in[95:64] = 32'h0000000a;
        request_in[95:64] = 32'h000001f4;
        xfer;
        chk("slew", 1'b1, cw[34]);
        request_in[95:64] = 32'h0;
        at_target_in = 6'h04;
        xfer;
        chk("slew off", 1'b0, cw[34]);
        request_raw_in[31:0] = 32'h7fc00000;
        xfer;
        chk("nan", 7'h7e, {cw[5], upd_s});
        request_raw_in[31:0] = 32'h0;
        float_mode_in = 1'b0;
        hold_enter_in = 6'h20;
        request_in[191:160] = 32'h000001f4;
        xfer;
        hold_enter_in = 6'h00;
        echo_in[191:160] = 32'h000001e9;
        xfer;
        chk("hold", 4'b1100, {hq[5], cw[4], cw[14], upd_s[5]});
        echo_in[191:160] = 32'h000001ef;
        xfer;
        chk("release", 2'b00, {hq[5], cw[4]});
        float_mode_in = 1'b1;
        hold_enter_in = 6'h20;
        xfer;
        hold_enter_in = 6'h00;
        chk("float hold", 3'b110, {cw[83], hq[5], upd_s[5]});
        // Reset in mid-run with a link failure pending behind the synchroniser
        comm_fail_in = 1'b1;
        rst_in = 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        chk("reset run", 128'h0, {mf, pc, cw});
        chk("reset hold", 13'h0, {hq, upd, tv});
        rst_in = 1'b0;
        @(posedge clk_in);
        #1;
        chk("first edge", 128'h0, {mf, pc, cw});
        repeat (2) @(posedge clk_in);
        #1;
        chk("comm after reset", {16'ha000, 16'hffff}, {mf, pc});
        results;
    end
endmodule // aofs_top_tb
`default_nettype wire
